// ==== logic/pdc_pkg.sv ====
// shared constants for the pll divider and output configuration block
package pdc_pkg;
	localparam int unsigned DIV_W        = 7;
	localparam int unsigned NUM_DIV      = 5;
	localparam int unsigned NUM_PHASE    = 4;
	// divider slots
	localparam int unsigned DIV_PRIMARY  = 0;
	localparam int unsigned DIV_SEC1     = 1;
	localparam int unsigned DIV_SEC2     = 2;
	localparam int unsigned DIV_FEEDBACK = 3;
	localparam int unsigned DIV_INPUT    = 4;
	// register byte offsets
	localparam logic [7:0] OFF_CFG_LO  = 8'h00;
	localparam logic [7:0] OFF_CFG_MID = 8'h04;
	localparam logic [7:0] OFF_CFG_HI  = 8'h08;
	localparam logic [7:0] OFF_CTRL    = 8'h0C;
	localparam logic [7:0] OFF_STATUS  = 8'h10;
	// field positions in the low word, bits 31..0
	localparam int unsigned POS_PRI_PHASE = 29;
	localparam int unsigned POS_SEC2_DIV  = 24;
	localparam int unsigned POS_SEC1_DIV  = 19;
	localparam int unsigned POS_PRI_DIV   = 14;
	localparam int unsigned POS_FB_DIV    = 7;
	localparam int unsigned POS_IN_DIV    = 0;
	// field positions in the middle word, bits 63..32
	localparam int unsigned POS_SEC1_PHASE = 0;
	// field positions in the high word, bits 95..64
	localparam int unsigned POS_RESYNC_EN  = 16;
	localparam int unsigned POS_DYN_BITS   = 17;
	localparam int unsigned DYN_BITS_W     = 8;
	// control and status bits
	localparam int unsigned POS_UPDATE     = 0;
	localparam int unsigned POS_PENDING    = 8;
	// values after reset
	localparam logic [31:0] RST_CFG_LO     = 32'h0000_0000;
	localparam logic [2:0]  RST_SEC1_PHASE = 3'h0;
	localparam logic [7:0]  RST_DYN_BITS   = 8'h00;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// ==== logic/pdc_div_if.sv ====
// carrier between the top and one output divider
`timescale 1ns/1ps
interface pdc_div_if;
	import pdc_pkg::*;
	logic [DIV_W-1:0] ratio_m1;
	logic             src_edge;
	logic             src_level;
	logic             resync;
	logic             div_out;
	modport ctrl (output ratio_m1, src_edge, src_level, resync,
		input div_out);
	modport div (input ratio_m1, src_edge, src_level, resync,
		output div_out);
endinterface

// ==== logic/pdc_clkdiv.sv ====
// one programmable divider, ratio is the stored field plus one
`timescale 1ns/1ps
module pdc_clkdiv (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	// divider link
	pdc_div_if.div    dv
);
	import pdc_pkg::*;

	logic [DIV_W-1:0] cnt_reg;
	logic             out_reg;
	logic [DIV_W:0]   ratio_p1;
	logic [DIV_W-1:0] half;

	assign ratio_p1 = {1'b0, dv.ratio_m1} + {{DIV_W{1'b0}}, 1'b1};
	assign half     = ratio_p1[DIV_W:1];
	assign dv.div_out = out_reg;

	always_ff @(posedge clk_in) begin
		if (rst_in || dv.resync) begin
			cnt_reg <= '0;
		end else if (dv.src_edge) begin
			// >= so a smaller ratio loaded mid-count wraps at once
			if (cnt_reg >= dv.ratio_m1)
				cnt_reg <= '0;
			else
				cnt_reg <= cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in || dv.resync)
			out_reg <= 1'b0;
		else if (dv.ratio_m1 == '0)
			out_reg <= dv.src_level;
		else
			out_reg <= (cnt_reg < half);
	end
endmodule

// ==== logic/pdc_top.sv ====
// pll output mux and divider configuration with an axi4-lite slave
//
// What this block does
// - primary phase select, bits 31..29, picks one of four phases
// - secondary-2 outputs divided by bits 28..24 plus one
// - secondary-1 outputs divided by bits 23..19 plus one
// - primary output divided by bits 18..14 plus one
// - feedback path divided by bits 13..7 plus one
// - reference clock divided by bits 6..0 plus one, output held high when the field is zero
// - bits 88..81 exist only in the dynamic variant
// - read-only bit 80 high resyncs all dividers on update
// - secondary-1 phase select, bits 34..32, picks one of four phases
`timescale 1ns/1ps
module pdc_top #(
	parameter bit RESYNC_EN       = 1'b1,
	parameter bit DYNAMIC_VARIANT = 1'b0
) (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// oscillator phases, asynchronous
	input  wire logic [pdc_pkg::NUM_PHASE-1:0] vco_phase_in,
	// axi4-lite write
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	// clock outputs
	output logic             primary_global_clock_out,
	output logic             secondary1_global_clock_out,
	output logic             secondary1_local_clock_out,
	output logic             secondary2_global_clock_out,
	output logic             secondary2_local_clock_out,
	output logic             feedback_div_out,
	output logic             input_div_out
);
	import pdc_pkg::*;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} pdc_wr_state_t;
	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_DATA = 2'b10
	} pdc_rd_state_t;

	pdc_wr_state_t wr_state_reg;
	pdc_rd_state_t rd_state_reg;

	logic        awready_reg, wready_reg, bvalid_reg;
	logic        arready_reg, rvalid_reg;
	logic [1:0]  bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic        aw_have_reg, w_have_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        wr_fire;

	// shadow words written by software, active words drive the dividers
	logic [31:0] cfg_lo_reg, act_lo_reg;
	logic [2:0]  sec1_phase_reg, act_sec1_phase_reg;
	logic [7:0]  dyn_bits_reg;
	logic        update_reg;
	logic        resync_reg;

	logic [NUM_PHASE-1:0] ph_s1_reg, ph_s2_reg, ph_s3_reg;
	logic [NUM_PHASE-1:0] ph_lvl_reg, ph_prev_reg;
	logic [NUM_PHASE-1:0] ph_edge;
	logic [1:0]           pri_sel, sec1_sel;

	logic [DIV_W-1:0] ratio [NUM_DIV];
	logic             src_edge [NUM_DIV];
	logic             src_level [NUM_DIV];
	logic [NUM_DIV-1:0] div_q;

	assign s_axi_awready_out = awready_reg;
	assign s_axi_wready_out  = wready_reg;
	assign s_axi_bvalid_out  = bvalid_reg;
	assign s_axi_bresp_out   = bresp_reg;
	assign s_axi_arready_out = arready_reg;
	assign s_axi_rvalid_out  = rvalid_reg;
	assign s_axi_rresp_out   = rresp_reg;
	assign s_axi_rdata_out   = rdata_reg;

	assign wr_fire = (wr_state_reg == WR_IDLE) && aw_have_reg && w_have_reg;

	// write channel: address and data taken in either order
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_state_reg <= WR_IDLE;
			awready_reg  <= 1'b1;
			wready_reg   <= 1'b1;
			aw_have_reg  <= 1'b0;
			w_have_reg   <= 1'b0;
			aw_addr_reg  <= 8'h00;
			w_data_reg   <= 32'h0000_0000;
			w_strb_reg   <= 4'h0;
			bvalid_reg   <= 1'b0;
			bresp_reg    <= RESP_OKAY;
		end else begin
			case (wr_state_reg)
			WR_IDLE: begin
				if (s_axi_awvalid_in && awready_reg) begin
					aw_have_reg <= 1'b1;
					aw_addr_reg <= s_axi_awaddr_in;
					awready_reg <= 1'b0;
				end
				if (s_axi_wvalid_in && wready_reg) begin
					w_have_reg <= 1'b1;
					w_data_reg <= s_axi_wdata_in;
					w_strb_reg <= s_axi_wstrb_in;
					wready_reg <= 1'b0;
				end
				if (wr_fire) begin
					wr_state_reg <= WR_RESP;
					bvalid_reg   <= 1'b1;
					if (aw_addr_reg == OFF_CFG_LO ||
						aw_addr_reg == OFF_CFG_MID ||
						aw_addr_reg == OFF_CFG_HI ||
						aw_addr_reg == OFF_CTRL)
						bresp_reg <= RESP_OKAY;
					else
						bresp_reg <= RESP_SLVERR;
				end
			end
			WR_RESP: begin
				if (s_axi_bready_in) begin
					wr_state_reg <= WR_IDLE;
					bvalid_reg   <= 1'b0;
					aw_have_reg  <= 1'b0;
					w_have_reg   <= 1'b0;
					awready_reg  <= 1'b1;
					wready_reg   <= 1'b1;
				end
			end
			default: wr_state_reg <= WR_IDLE;
			endcase
		end
	end

	// shadow registers, byte lanes honoured
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cfg_lo_reg     <= RST_CFG_LO;
			sec1_phase_reg <= RST_SEC1_PHASE;
			dyn_bits_reg   <= RST_DYN_BITS;
		end else if (wr_fire) begin
			if (aw_addr_reg == OFF_CFG_LO) begin
				for (int b = 0; b < 4; b++) begin
					if (w_strb_reg[b])
						cfg_lo_reg[8*b +: 8] <= w_data_reg[8*b +: 8];
				end
			end else if (aw_addr_reg == OFF_CFG_MID) begin
				if (w_strb_reg[0])
					sec1_phase_reg <= w_data_reg[POS_SEC1_PHASE +: 3];
			end else if (aw_addr_reg == OFF_CFG_HI) begin
				// bit 80 is read-only, only the variant bits store
				if (DYNAMIC_VARIANT && w_strb_reg[2] && w_strb_reg[3])
					dyn_bits_reg <= w_data_reg[POS_DYN_BITS +: DYN_BITS_W];
			end
		end
	end

	// update strobe and application of the shadow words
	always_ff @(posedge clk_in) begin
		if (rst_in)
			update_reg <= 1'b0;
		else
			update_reg <= wr_fire && (aw_addr_reg == OFF_CTRL) &&
				w_strb_reg[0] && w_data_reg[POS_UPDATE];
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			act_lo_reg         <= RST_CFG_LO;
			act_sec1_phase_reg <= RST_SEC1_PHASE;
		end else if (update_reg) begin
			act_lo_reg         <= cfg_lo_reg;
			act_sec1_phase_reg <= sec1_phase_reg;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in)
			resync_reg <= 1'b0;
		else
			resync_reg <= update_reg && RESYNC_EN;
	end

	// read channel, answers one cycle after the address is taken
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rd_state_reg <= RD_IDLE;
			arready_reg  <= 1'b1;
			rvalid_reg   <= 1'b0;
			rresp_reg    <= RESP_OKAY;
			rdata_reg    <= 32'h0000_0000;
		end else begin
			case (rd_state_reg)
			RD_IDLE: begin
				if (s_axi_arvalid_in) begin
					rd_state_reg <= RD_DATA;
					arready_reg  <= 1'b0;
					rvalid_reg   <= 1'b1;
					rresp_reg    <= RESP_OKAY;
					if (s_axi_araddr_in == OFF_CFG_LO) begin
						rdata_reg <= cfg_lo_reg;
					end else if (s_axi_araddr_in == OFF_CFG_MID) begin
						rdata_reg <= {29'h0, sec1_phase_reg};
					end else if (s_axi_araddr_in == OFF_CFG_HI) begin
						rdata_reg <= {7'h0,
							DYNAMIC_VARIANT ? dyn_bits_reg : 8'h00,
							RESYNC_EN, 16'h0000};
					end else if (s_axi_araddr_in == OFF_CTRL) begin
						rdata_reg <= 32'h0000_0000;
					end else if (s_axi_araddr_in == OFF_STATUS) begin
						rdata_reg <= {23'h0,
							(cfg_lo_reg != act_lo_reg) ||
							(sec1_phase_reg != act_sec1_phase_reg),
							3'h0, div_q};
					end else begin
						rdata_reg <= 32'h0000_0000;
						rresp_reg <= RESP_SLVERR;
					end
				end
			end
			RD_DATA: begin
				if (s_axi_rready_in) begin
					rd_state_reg <= RD_IDLE;
					rvalid_reg   <= 1'b0;
					arready_reg  <= 1'b1;
				end
			end
			default: rd_state_reg <= RD_IDLE;
			endcase
		end
	end

	// phase inputs: three flops, a change counts when stages two and
	// three agree, so a glitch shorter than a cycle is dropped
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ph_s1_reg   <= '0;
			ph_s2_reg   <= '0;
			ph_s3_reg   <= '0;
			ph_lvl_reg  <= '0;
			ph_prev_reg <= '0;
		end else begin
			ph_s1_reg   <= vco_phase_in;
			ph_s2_reg   <= ph_s1_reg;
			ph_s3_reg   <= ph_s2_reg;
			ph_lvl_reg  <= (ph_s2_reg & ph_s3_reg) |
				(ph_lvl_reg & (ph_s2_reg | ph_s3_reg));
			ph_prev_reg <= ph_lvl_reg;
		end
	end
	assign ph_edge = ph_lvl_reg & ~ph_prev_reg;

	// only four phases exist, so the top select bit is ignored
	assign pri_sel  = act_lo_reg[POS_PRI_PHASE +: 2];
	assign sec1_sel = act_sec1_phase_reg[1:0];

	always_comb begin
		ratio[DIV_PRIMARY]  = {2'b00, act_lo_reg[POS_PRI_DIV +: 5]};
		ratio[DIV_SEC1]     = {2'b00, act_lo_reg[POS_SEC1_DIV +: 5]};
		ratio[DIV_SEC2]     = {2'b00, act_lo_reg[POS_SEC2_DIV +: 5]};
		ratio[DIV_FEEDBACK] = act_lo_reg[POS_FB_DIV +: DIV_W];
		ratio[DIV_INPUT]    = act_lo_reg[POS_IN_DIV +: DIV_W];
		src_edge[DIV_PRIMARY]   = ph_edge[pri_sel];
		src_level[DIV_PRIMARY]  = ph_lvl_reg[pri_sel];
		src_edge[DIV_SEC1]      = ph_edge[sec1_sel];
		src_level[DIV_SEC1]     = ph_lvl_reg[sec1_sel];
		src_edge[DIV_SEC2]      = ph_edge[0];
		src_level[DIV_SEC2]     = ph_lvl_reg[0];
		src_edge[DIV_FEEDBACK]  = ph_edge[0];
		src_level[DIV_FEEDBACK] = ph_lvl_reg[0];
		// reference clock counted once per cycle
		src_edge[DIV_INPUT]     = 1'b1;
		src_level[DIV_INPUT]    = 1'b1;
	end

	generate
		for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
			pdc_div_if dif ();
			assign dif.ratio_m1  = ratio[i];
			assign dif.src_edge  = src_edge[i];
			assign dif.src_level = src_level[i];
			assign dif.resync    = resync_reg;
			assign div_q[i]      = dif.div_out;
			pdc_clkdiv u_div (
				.clk_in (clk_in),
				.rst_in (rst_in),
				.dv     (dif.div)
			);
		end
	endgenerate

	// local and global copies of a secondary share one divider flop
	assign primary_global_clock_out    = div_q[DIV_PRIMARY];
	assign secondary1_global_clock_out = div_q[DIV_SEC1];
	assign secondary1_local_clock_out  = div_q[DIV_SEC1];
	assign secondary2_global_clock_out = div_q[DIV_SEC2];
	assign secondary2_local_clock_out  = div_q[DIV_SEC2];
	assign feedback_div_out            = div_q[DIV_FEEDBACK];
	assign input_div_out               = div_q[DIV_INPUT];
endmodule

// ==== test/pdc_vco_model.sv ====
// oscillator model: four phases of one four-cycle square wave
`timescale 1ns/1ps
module pdc_vco_model (
	// clock
	input  wire logic       clk_in,
	// oscillator phases
	output logic      [3:0] phase_out
);
	logic [1:0] cnt_reg = 2'h0;
	// free running, like the real oscillator, so no reset
	always_ff @(posedge clk_in) begin
		cnt_reg <= cnt_reg + 2'h1;
	end
	// phase k leads phase 0 by k clock periods
	always_comb begin
		logic [1:0] s;
		s = 2'h0;
		for (int k = 0; k < 4; k++) begin
			s = cnt_reg + 2'(k);
			phase_out[k] = s[1];
		end
	end
endmodule

// ==== test/pdc_top_props.sv ====
// port checker for the pll divider configuration block
`timescale 1ns/1ps
module pdc_top_props #(
	parameter bit RESYNC_EN       = 1'b1,
	parameter bit DYNAMIC_VARIANT = 1'b0
) (
	// clock and reset
	input wire logic        clk_in,
	input wire logic        rst_in,
	// axi4-lite
	input wire logic        s_axi_awvalid_in,
	input wire logic        s_axi_awready_out,
	input wire logic        s_axi_wvalid_in,
	input wire logic        s_axi_wready_out,
	input wire logic [1:0]  s_axi_bresp_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic [7:0]  s_axi_araddr_in,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0]  s_axi_rresp_out,
	input wire logic        s_axi_rvalid_out,
	// clock outputs
	input wire logic        primary_global_clock_out,
	input wire logic        secondary1_global_clock_out,
	input wire logic        secondary1_local_clock_out,
	input wire logic        secondary2_global_clock_out,
	input wire logic        secondary2_local_clock_out,
	input wire logic        input_div_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic ar_take;
	assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
	wr_resp_lat_a: assert property (s_axi_awvalid_in && s_axi_awready_out
		&& s_axi_wvalid_in && s_axi_wready_out
		|=> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
		else $error("write response not two cycles after take");
	wr_resp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in
		|=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped before bready");
	wr_ready_back_a: assert property (s_axi_bvalid_out && s_axi_bready_in
		|=> s_axi_awready_out && s_axi_wready_out && !s_axi_bvalid_out)
		else $error("write channel not reopened after response");
	rd_data_lat_a: assert property (ar_take
		|=> s_axi_rvalid_out && !s_axi_arready_out)
		else $error("read data not one cycle after take");
	rd_bad_addr_a: assert property (ar_take && s_axi_araddr_in > 8'h10
		|=> s_axi_rresp_out == 2'h2 && s_axi_rdata_out == 32'h0)
		else $error("unmapped read not refused");
	resync_bit_a: assert property (ar_take && s_axi_araddr_in == 8'h08
		|=> s_axi_rdata_out[16] == RESYNC_EN)
		else $error("resync enable bit wrong");
	dyn_bits_a: assert property (ar_take && s_axi_araddr_in == 8'h08
		&& !DYNAMIC_VARIANT |=> s_axi_rdata_out[24:17] == 8'h00)
		else $error("variant bits present in plain variant");
	sec_pairs_a: assert property (
		secondary1_global_clock_out == secondary1_local_clock_out
		&& secondary2_global_clock_out == secondary2_local_clock_out)
		else $error("global and local outputs differ");
	rst_quiet_a: assert property (disable iff (1'b0) rst_in
		|=> !s_axi_bvalid_out && !s_axi_rvalid_out
		&& !primary_global_clock_out && !input_div_out)
		else $error("outputs not cleared by reset");
endmodule
bind pdc_top pdc_top_props #(.RESYNC_EN(RESYNC_EN),
	.DYNAMIC_VARIANT(DYNAMIC_VARIANT)) u_props (.clk_in, .rst_in,
	.s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
	.s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
	.s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
	.s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
	.s_axi_rvalid_out, .primary_global_clock_out,
	.secondary1_global_clock_out, .secondary1_local_clock_out,
	.secondary2_global_clock_out, .secondary2_local_clock_out,
	.input_div_out);

// ==== test/tb_top.sv ====
// self-checking bench for the pll divider configuration block
`timescale 1ns/1ps
module tb_top;
	import pdc_pkg::*;
	logic        clk_in, rst_in, awv, wv, bready, arv, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, d, w, cur;
	logic [1:0]  r;
	logic [3:0]  vco;
	logic [4:0]  last;
	wire logic        awr, wr, bv, arr, rv, s1l, s2l;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [4:0]  outs;
	int n_fail, checks_done, seed, cyc;
	int rise_t[5], prev_t[5];

	pdc_vco_model VCO (.clk_in(clk_in), .phase_out(vco));
	pdc_top DUT (.clk_in(clk_in), .rst_in(rst_in), .vco_phase_in(vco),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
		.s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wr), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bv), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
		.s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rready), .primary_global_clock_out(outs[0]),
		.secondary1_global_clock_out(outs[1]),
		.secondary1_local_clock_out(s1l),
		.secondary2_global_clock_out(outs[2]),
		.secondary2_local_clock_out(s2l),
		.feedback_div_out(outs[3]), .input_div_out(outs[4]));

	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	// rise times of each divider output, in clock cycles
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		last <= outs;
		for (int i = 0; i < 5; i++) if (outs[i] && !last[i]) begin
			prev_t[i] <= rise_t[i];
			rise_t[i] <= cyc;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task axw(input logic [7:0] a, input logic [31:0] dd,
		output logic [1:0] rr);
		@(posedge clk_in);
		awaddr <= a;
		wdata <= dd;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_in);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (bv !== 1'b1);
		rr = bresp;
		bready <= 1'b0;
	endtask
	task axr(input logic [7:0] a, output logic [31:0] dd,
		output logic [1:0] rr);
		@(posedge clk_in);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_in);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		dd = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask
	// apply the shadow words, then let every divider settle
	task upd_wait;
		axw(OFF_CTRL, 32'h1, r);
		repeat (100) @(posedge clk_in);
	endtask
	// expected period in clock cycles; phases last four cycles
	function int per(int i, logic [31:0] x);
		case (i)
			0: per = (x[18:14] + 1) * 4;
			1: per = (x[23:19] + 1) * 4;
			2: per = (x[28:24] + 1) * 4;
			3: per = (x[13:7] + 1) * 4;
			default: per = x[6:0] + 1;
		endcase
	endfunction
	task stop_test;
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_in);
		n_fail++;
		stop_test;
	end
	initial begin
		logic [7:0] ad[5];
		logic [31:0] ex[5];
		ad = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14};
		ex = '{32'h0, 32'h0, 32'h0001_0000, 32'h0, 32'h0};
		seed = 32'h2a72;
		{awv, wv, bready, arv, rready, awaddr, araddr, wdata} = '0;
		cyc = 0;
		last = 5'h00;
		rst_in = 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			axr(ad[i], d, r);
			chk(d, ex[i]);
			chk(r, i == 4 ? RESP_SLVERR : RESP_OKAY);
		end
		$display("reset values done");
		axw(OFF_CFG_HI, $random(seed), r);
		axr(OFF_CFG_HI, d, r);
		chk(d, 32'h0001_0000);
		axw(8'h14, 32'hFFFF_FFFF, r);
		chk(r, RESP_SLVERR);
		w = $random(seed);
		axw(OFF_CFG_MID, w, r);
		axr(OFF_CFG_MID, d, r);
		chk(d, w & 32'h7);
		$display("access done");
		// all but the reference divider divide by one, so phase offsets show directly
		for (int k = 0; k < 8; k++) begin
			cur = (k << 29) | 32'h1;
			axw(OFF_CFG_LO, cur, r);
			axw(OFF_CFG_MID, (k + 1) & 7, r);
			upd_wait;
			chk((rise_t[0] - rise_t[2]) & 3, (-k) & 3);
			chk((rise_t[1] - rise_t[2]) & 3, (-(k + 1)) & 3);
		end
		$display("phase select done");
		for (int it = 0; it < 4; it++) begin
			w = $random(seed) & 32'hE739_C387;
			if (w[2:0] == 3'h0) w[0] = 1'b1;
			// a repeat of the active word would leave nothing pending
			if (w == cur) w[24] = ~w[24];
			axw(OFF_CFG_LO, w, r);
			chk(r, RESP_OKAY);
			repeat (100) @(posedge clk_in);
			for (int i = 0; i < 5; i++)
				chk(rise_t[i] - prev_t[i], per(i, cur));
			axr(OFF_STATUS, d, r);
			chk(d[POS_PENDING], 1'b1);
			upd_wait;
			for (int i = 0; i < 5; i++)
				chk(rise_t[i] - prev_t[i], per(i, w));
			axr(OFF_STATUS, d, r);
			chk(d[POS_PENDING], 1'b0);
			cur = w;
		end
		$display("dividers done");
		stop_test;
	end
endmodule
